// ==== core/irq_ctrl_pkg.sv ====
/*
 * Types of the two-level interrupt controller.
 * Assumes irq_ctrl_regs.svh for all numeric figures.
 */
package irq_ctrl_pkg;
   typedef enum logic [1:0] {st_idle, st_wait, st_entry} entry_state_t;
   typedef logic [20:0] vector_t;
endpackage : irq_ctrl_pkg

// ==== core/irq_ctrl_regs.svh ====
/*
 * Register offsets, field positions, reset values and fixed figures of the
 * two-level interrupt controller. Assumes a 32-bit AHB-Lite register bus.
 */
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH

// ==========================================================================
// register byte offsets
`define OFF_GLOBAL_CONTROL 12'h000
`define OFF_SOURCE_FLAG 12'h004
`define OFF_SOURCE_ENABLE 12'h008
`define OFF_PRIORITY_SELECT 12'h00c
`define OFF_FLAG_CLEAR 12'h010
`define OFF_SERVICE_STATUS 12'h014

// ==========================================================================
// interrupt_global_control fields
`define BIT_HIGH_ENABLE 7
`define BIT_LOW_ENABLE 6
`define BIT_LEVELS_ENABLE 5
`define BIT_EDGE2 2
`define BIT_EDGE0 0
`define CTRL_WRITE_MASK 8'he7
`define CTRL_RESET 8'h07

// ==========================================================================
// vectors and latency
`define VECTOR_HIGH 21'h000008
`define VECTOR_LOW 21'h000018
`define LATENCY_INSTR_CYCLES 3
`define PIN_SYNC_STAGES 3

`endif

// ==== core/irq_priority_ctrl.sv ====
/*
 * Two-level interrupt priority controller: global enables, per-source
 * flag/enable/priority, external pin edge detection, vectoring handshake
 * with the CPU core and return handling, over an AHB-Lite slave.
 * Assumes a CPU that advances on i_instr_cycle, acknowledges an entry
 * with i_entry_ack after pushing the return address, and pulses
 * i_return_exec when it executes the return-from-interrupt instruction.
 */
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.svh"

// Function
// - priority selects ignored unless levels enabled
// - compat: peripherals need both enables set
// - compat: high enable gates everything
// - compat: every entry vectors to 0008h
// - levels bit switches bits 7/6 meaning
// - priority mode: high enable admits high sources
// - cleared high enable blocks all sources
// - low sources need high and low enables
// - high to 0008h, low to 0018h
// - entry clears the matching global enable
// - high preempts low; low waits for high
// - CPU pushes return address, loads vector
// - return re-sets the enable cleared at entry
// - pin event latency three to four cycles
// - flags set regardless of any enable
// - vectors fixed; high interrupts low routine
// - each source has flag, enable, priority
module irq_priority_ctrl #(
   parameter int NUM_PERIPH = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_hsel,
   input wire logic [11:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   input wire logic [2:0] i_ext_irq_pin,
   input wire logic [NUM_PERIPH-1:0] i_periph_event,
   input wire logic i_instr_cycle,
   input wire logic i_entry_ack,
   input wire logic i_return_exec,
   output logic o_entry_req,
   output logic [20:0] o_entry_vector
);
   import irq_ctrl_pkg::*;

   // flag layout: pins in the low three bits, peripherals above them

   localparam int NSRC = NUM_PERIPH + 3;

   // =======================================================================
   // state
   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      logic ph_wr;
      logic [11:0] ph_addr;
      logic [7:0] ctrl;
      logic [NSRC-1:0] flag;
      logic [NSRC-1:0] enable;
      logic [NSRC-1:0] prio;
      logic [2:0] pin_s1;
      logic [2:0] pin_s2;
      logic [2:0] pin_s3;
      entry_state_t est;
      logic [1:0] lat_cnt;
      logic ent_high;
      logic in_high;
      logic in_low;
      logic entry_req;
      vector_t vector;
   } state_t;

   state_t cur;
   state_t next_st;

   function automatic logic [31:0] pad(input logic [NSRC-1:0] v);
      pad = 32'h0;
      pad[NSRC-1:0] = v;
   endfunction : pad

   // =======================================================================
   // helpers

   // compat mode has one vector only, whatever the source
   function automatic vector_t pick_vector(input logic levels, input logic high);
      if (levels && !high)
      begin
         pick_vector = `VECTOR_LOW;
      end
      else
      begin
         pick_vector = `VECTOR_HIGH;
      end
   endfunction : pick_vector

   function automatic logic any_set(input logic [NSRC-1:0] v);
      any_set = (v != '0);
   endfunction : any_set

   // one decode for every readable word; unmapped words read zero
   function automatic logic [31:0] read_word(input logic [11:0] a, input state_t s);
      unique case (a)
         `OFF_GLOBAL_CONTROL:
            read_word = {24'h0, s.ctrl & `CTRL_WRITE_MASK};
         `OFF_SOURCE_FLAG:
            read_word = pad(s.flag);
         `OFF_SOURCE_ENABLE:
            read_word = pad(s.enable);
         `OFF_PRIORITY_SELECT:
            read_word = pad(s.prio);
         `OFF_SERVICE_STATUS:
            read_word = {29'h0, s.in_low, s.in_high, s.entry_req};
         default:
            read_word = 32'h0;
      endcase
   endfunction : read_word

   // set terms win: an event landing with a write-one-to-clear survives
   function automatic logic [NSRC-1:0] flag_update(input logic [NSRC-1:0] old_flags,
      input logic [NSRC-1:0] clr, input logic [NSRC-1:0] set);
      flag_update = (old_flags & ~clr) | set;
   endfunction : flag_update

   logic mode_levels;
   logic gh;
   logic gl;
   logic [2:0] pin_rise;
   logic [2:0] pin_fall;
   logic [2:0] pin_evt;
   logic [NSRC-1:0] pend;
   logic [NSRC-1:0] pend_hi;
   logic [NSRC-1:0] pend_lo;
   logic want_high;
   logic want_low;
   logic [NSRC-1:0] clr_mask;
   logic [NSRC-1:0] periph_mask;

   always_comb
   begin
      next_st = cur;
      mode_levels = cur.ctrl[`BIT_LEVELS_ENABLE];
      gh = cur.ctrl[`BIT_HIGH_ENABLE];
      gl = cur.ctrl[`BIT_LOW_ENABLE];
      periph_mask = '0;
      periph_mask[NSRC-1:3] = '1;
      clr_mask = '0;

      // =====================================================================
      // pin edge detection; only stages two and three are compared
      next_st.pin_s1 = i_ext_irq_pin;
      next_st.pin_s2 = cur.pin_s1;
      next_st.pin_s3 = cur.pin_s2;
      pin_rise = cur.pin_s2 & ~cur.pin_s3;
      pin_fall = ~cur.pin_s2 & cur.pin_s3;
      for (int i = 0; i < 3; i++)
      begin
         pin_evt[i] = cur.ctrl[`BIT_EDGE0 + i] ? pin_rise[i] : pin_fall[i];
      end

      // =====================================================================
      // request qualification
      pend = cur.flag & cur.enable;
      if (mode_levels)
      begin
         pend_hi = pend & cur.prio;
         pend_lo = pend & ~cur.prio;
         want_high = gh && any_set(pend_hi) && !cur.in_high;
         want_low = gh && gl && any_set(pend_lo) && !cur.in_high && !cur.in_low;
      end
      else
      begin
         // priority selects play no part here
         pend_hi = '0;
         pend_lo = '0;
         want_high = gh && (((pend & ~periph_mask) != '0)
                     || (gl && ((pend & periph_mask) != '0)));
         want_low = 1'b0;
      end

      // =====================================================================
      // entry handshake; the wait spans two instruction cycles so a
      // one- or two-cycle instruction in flight sees the same latency
      unique case (cur.est)
         st_idle:
         begin
            if (want_high || want_low)
            begin
               next_st.est = st_wait;
               next_st.lat_cnt = 2'h0;
               next_st.ent_high = want_high;
            end
         end
         st_wait:
         begin
            if (!(want_high || want_low))
            begin
               next_st.est = st_idle;
            end
            else if (i_instr_cycle)
            begin
               if (want_high)
               begin
                  next_st.ent_high = 1'b1;
               end
               next_st.lat_cnt = cur.lat_cnt + 2'h1;
               if (cur.lat_cnt == 2'(`LATENCY_INSTR_CYCLES - 2))
               begin
                  next_st.est = st_entry;
                  next_st.entry_req = 1'b1;
                  next_st.vector = pick_vector(mode_levels, cur.ent_high || want_high);
                  next_st.ent_high = cur.ent_high || want_high || !mode_levels;
               end
            end
         end
         st_entry:
         begin
            if (i_entry_ack)
            begin
               next_st.entry_req = 1'b0;
               next_st.est = st_idle;
               if (cur.ent_high)
               begin
                  next_st.ctrl[`BIT_HIGH_ENABLE] = 1'b0;
                  next_st.in_high = mode_levels;
               end
               else
               begin
                  next_st.ctrl[`BIT_LOW_ENABLE] = 1'b0;
                  next_st.in_low = 1'b1;
               end
            end
         end
      endcase

      // return restores the enable of the innermost routine
      if (i_return_exec)
      begin
         if (!mode_levels || cur.in_high)
         begin
            next_st.ctrl[`BIT_HIGH_ENABLE] = 1'b1;
            next_st.in_high = 1'b0;
         end
         else
         begin
            next_st.ctrl[`BIT_LOW_ENABLE] = 1'b1;
            next_st.in_low = 1'b0;
         end
      end

      // =====================================================================
      // AHB-Lite slave; zero wait states, always OKAY
      next_st.hreadyout = 1'b1;
      next_st.hresp = 1'b0;
      next_st.ph_wr = 1'b0;
      if (i_hsel && i_hready && i_htrans[1])
      begin
         next_st.ph_wr = i_hwrite;
         next_st.ph_addr = i_haddr;
      end
      if (cur.ph_wr)
      begin
         unique case (cur.ph_addr)
            `OFF_GLOBAL_CONTROL:
               next_st.ctrl = i_hwdata[7:0] & `CTRL_WRITE_MASK;
            `OFF_SOURCE_ENABLE:
               next_st.enable = i_hwdata[NSRC-1:0];
            `OFF_PRIORITY_SELECT:
               next_st.prio = i_hwdata[NSRC-1:0];
            `OFF_FLAG_CLEAR:
               clr_mask = i_hwdata[NSRC-1:0];
            default:
            begin
            end
         endcase
      end
      // set wins over a clear in the same cycle
      next_st.flag = flag_update(cur.flag, clr_mask, {i_periph_event, pin_evt});

      // decoded in the address phase so the registered word stands for
      // exactly the data phase; the address bus is free to move after it
      next_st.hrdata = 32'h0;
      if (i_hsel && i_hready && i_htrans[1] && !i_hwrite)
      begin
         next_st.hrdata = read_word(i_haddr, cur);
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         cur <= '0;
         cur.ctrl <= `CTRL_RESET;
         cur.est <= st_idle;
         // ready already high so the first edge after release may be taken
         cur.hreadyout <= 1'b1;
      end
      else
      begin
         cur <= next_st;
      end
   end

   assign o_hrdata = cur.hrdata;
   assign o_hreadyout = cur.hreadyout;
   assign o_hresp = cur.hresp;
   assign o_entry_req = cur.entry_req;
   assign o_entry_vector = cur.vector;

endmodule : irq_priority_ctrl
`default_nettype wire

// ==== test/cpu_model.sv ====
/* behavioural cpu core: instruction clock, entry ack, return pulse.
   assumes one request is acknowledged once, on a single clock. */
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_req,
   input wire logic i_ret,
   output logic o_instr,
   output logic o_ack,
   output logic o_retx,
   output logic [1:0] o_depth
);
   logic [1:0] div;
   logic busy;
   // ====================
   // core behaviour
   always_ff @(posedge i_clk)
   begin
      div <= i_rst_n ? div + 2'h1 : 2'h0;
      o_instr <= i_rst_n && div == 2'h3;
      // busy keeps a long request from being acked twice
      busy <= i_rst_n && (o_ack || busy) && i_req;
      o_ack <= i_rst_n && i_req && !o_ack && !busy;
      o_depth <= !i_rst_n ? 2'h0 : o_depth + {1'b0, o_ack} - {1'b0, i_ret};
      o_retx <= i_rst_n && i_ret;
   end
endmodule : cpu_model
`default_nettype wire

// ==== test/irq_ctrl_checker.sv ====
/* port assertions for the interrupt controller.
   assumes the design's top-level port names; bound below. */
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_checker (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_hsel,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic i_hready,
   input wire logic [31:0] o_hrdata,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic i_instr_cycle,
   input wire logic i_entry_ack,
   input wire logic o_entry_req,
   input wire logic [20:0] o_entry_vector
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   // ====================
   // entry handshake and bus
   AST_VEC: assert property (o_entry_req |-> o_entry_vector inside {21'h8, 21'h18})
      else $error("bad vector");
   AST_HOLD: assert property (o_entry_req && !i_entry_ack |=> o_entry_req)
      else $error("request dropped before ack");
   AST_DROP: assert property (o_entry_req && i_entry_ack |-> ##[1:2] !o_entry_req)
      else $error("request stuck after ack");
   AST_STEADY: assert property (o_entry_req && $past(o_entry_req) |-> $stable(o_entry_vector))
      else $error("vector moved");
   AST_RISE: assert property ($rose(o_entry_req) |-> $past(i_instr_cycle) || $past(i_instr_cycle, 2))
      else $error("entry off instruction boundary");
   AST_RDZERO: assert property (!$past(i_hsel && i_htrans[1] && !i_hwrite && i_hready)
      |-> o_hrdata == 32'h0)
      else $error("read data outside data phase");
   AST_OKAY: assert property (o_hreadyout && !o_hresp)
      else $error("bus not ready or not okay");
   AST_RST: assert property (disable iff (1'b0) !i_rst_n |=> !o_entry_req && o_hrdata == 32'h0)
      else $error("outputs active after reset");
endmodule : irq_ctrl_checker
bind irq_priority_ctrl irq_ctrl_checker u_irq_ctrl_checker (.*);
`default_nettype wire

// ==== test/irq_priority_ctrl_bench.sv ====
/* self-checking bench for the interrupt controller.
   assumes cpu_model as core and zero-wait ahb reads. */
`timescale 1ns/1ps
`default_nettype none
module irq_priority_ctrl_bench;
   logic i_ref_clk = 0, i_rst_n = 0, i_hsel = 0, i_hwrite = 0, ret = 0;
   logic [11:0] i_haddr = 0;
   logic [1:0] i_htrans = 0, depth;
   logic [2:0] i_hsize = 3'h2, i_ext_irq_pin = 0;
   logic [31:0] i_hwdata = 0, o_hrdata;
   logic [7:0] i_periph_event = 0;
   logic i_hready, o_hreadyout, o_hresp, i_instr_cycle, i_entry_ack, i_return_exec, o_entry_req;
   logic [20:0] o_entry_vector;
   int miscompares = 0, total_checks = 0;
   assign i_hready = o_hreadyout;
   always #2.5 i_ref_clk = ~i_ref_clk;
   irq_priority_ctrl u_irq_priority_ctrl (.*);
   cpu_model u_cpu_model (.i_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_req(o_entry_req),
      .i_ret(ret), .o_instr(i_instr_cycle), .o_ack(i_entry_ack), .o_retx(i_return_exec),
      .o_depth(depth));
   // ====================
   // tasks
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] %0t got %h want %h", $time, g, e);
      end
   endtask : check
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
      i_hsel <= 1'b1;
      i_haddr <= a;
      i_hwrite <= w;
      i_htrans <= 2'h2;
      @(posedge i_ref_clk);
      while (o_hreadyout !== 1'b1) @(posedge i_ref_clk);
      i_htrans <= 2'h0;
      i_hwdata <= d;
      @(posedge i_ref_clk);
      while (o_hreadyout !== 1'b1) @(posedge i_ref_clk);
      q = o_hrdata;
   endtask : bus
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, e);
   endtask : rd
   task automatic pulse();
      i_periph_event <= 8'h01;
      @(posedge i_ref_clk);
      i_periph_event <= 8'h00;
   endtask : pulse
   task automatic retn();
      ret <= 1'b1;
      @(posedge i_ref_clk);
      ret <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
   endtask : retn
   task automatic quiet();
      logic s;
      s = 1'b0;
      repeat (60)
      begin
         @(posedge i_ref_clk);
         s = s | o_entry_req;
      end
      check(32'(s), 32'h0);
   endtask : quiet
   task automatic expect_req(input logic [20:0] v, input logic pin);
      int n;
      int p;
      n = 0;
      p = 0;
      while (o_entry_req !== 1'b1 && n < 60)
      begin
         @(posedge i_ref_clk);
         n++;
         p += i_instr_cycle;
      end
      check(32'({o_entry_req, o_entry_vector}), 32'({1'b1, v}));
      if (pin)
         check(32'(p > 1 && p < 5), 32'h1);
      repeat (4) @(posedge i_ref_clk);
   endtask : expect_req
   task automatic results();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results
   // ====================
   // sequence
   initial
   begin
      repeat (5) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      @(posedge i_ref_clk);
      rd(12'h000, 32'h07);
      wr(12'h000, 32'hff);
      rd(12'h000, 32'he7);
      rd(12'h020, 32'h0);
      wr(12'h000, 32'h07);
      wr(12'h00c, 32'h08);
      wr(12'h008, 32'h09);
      pulse();
      rd(12'h004, 32'h08);
      wr(12'h000, 32'h87);
      quiet();
      wr(12'h000, 32'hc7);
      expect_req(21'h8, 1'b0);
      rd(12'h000, 32'h47);
      wr(12'h010, 32'h08);
      retn();
      rd(12'h000, 32'hc7);
      wr(12'h000, 32'h67);
      pulse();
      quiet();
      wr(12'h00c, 32'h01);
      wr(12'h000, 32'he7);
      expect_req(21'h18, 1'b0);
      rd(12'h000, 32'ha7);
      i_ext_irq_pin <= 3'h1;
      expect_req(21'h8, 1'b1);
      rd(12'h000, 32'h27);
      check(32'(depth), 32'h2);
      wr(12'h010, 32'h09);
      retn();
      rd(12'h000, 32'ha7);
      retn();
      rd(12'h000, 32'he7);
      wr(12'h000, 32'h06);
      i_ext_irq_pin <= 3'h0;
      repeat (8) @(posedge i_ref_clk);
      rd(12'h004, 32'h01);
      results();
   end
   initial
   begin
      #20us;
      miscompares++;
      results();
   end
endmodule : irq_priority_ctrl_bench
`default_nettype wire
